// file: rtl/baud_down_counter.sv
`timescale 1ns/1ps
module baud_down_counter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [15:0] reload,
    // Half-bit tick and present count
    output logic tick,
    output logic [15:0] count
);

    sscc_pkg::baud_state_t r;
    sscc_pkg::baud_state_t next_r;

    // One tick per reload is half a bit, so a bit is 2*(reload+1) clocks
    always_comb begin
        next_r.tick = 1'b0;
        next_r.cnt = r.cnt;
        if (!run) begin
            next_r.cnt = reload;
        end else if (r.cnt == 16'h0000) begin
            next_r.cnt = reload;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
    assign count = r.cnt;

endmodule

// file: rtl/pin_sync_2ff.sv
`timescale 1ns/1ps
module pin_sync_2ff (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins in, synchronised levels out
    input wire logic [2:0] d,
    output logic [2:0] q
);

    sscc_pkg::sync_state_t r;
    sscc_pkg::sync_state_t next_r;

    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;

endmodule

// file: rtl/sscc_defines.svh
`ifndef SSCC_DEFINES_SVH
`define SSCC_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL 16'hffb2
`define IDX_TB 16'hf0b0
`define IDX_RB 16'hf0b2
`define IDX_BR 16'hf0b4
`define IDX_PIN 16'hf0b6
`define IDX_TIC 16'hff72
`define IDX_RIC 16'hff74
`define IDX_EIC 16'hff76

// Control register fields
`define CTRL_EN 15
`define CTRL_MS 14
`define CTRL_BSY 12
`define CTRL_ERR 11:8
`define CTRL_PO 6
`define CTRL_PH 5
`define CTRL_HB 4
`define CTRL_BM 3:0

// Error kinds inside the error field
`define ERR_TX 0
`define ERR_RX 1
`define ERR_PHASE 2
`define ERR_BAUD 3

// Interrupt control fields
`define IC_REQ 7
`define IC_EN 6

// Pin control fields
`define PIN_LATCH 2:0
`define PIN_DIR 10:8
`define PIN_OD 18:16

// Reset values
`define BR_RESET 16'h0000
`define IC_RESET 8'h00
`define PIN_RESET 3'h0

// Slave baud ticks without a clock edge tolerated before a rate error
`define BAUD_ERR_TICKS 2'h3

`endif

// file: rtl/sscc_pkg.sv
package sscc_pkg;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_RUN = 2'b01
    } xfer_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
    } sync_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } baud_state_t;

    typedef struct packed {
        logic en;
        logic ms;
        logic [3:0] err_en;
        logic [3:0] err_flag;
        logic po;
        logic ph;
        logic hb;
        logic [3:0] bm;
        logic [3:0] bc;
        logic busy;
        logic [15:0] tb;
        logic tb_full;
        logic [15:0] rb;
        logic rb_full;
        logic [15:0] br;
        logic [7:0] tic;
        logic [7:0] ric;
        logic [7:0] eic;
        logic [2:0] latch;
        logic [2:0] dir;
        logic [2:0] od;
        xfer_t st;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [4:0] k;
        logic edge2;
        logic sclk_alt;
        logic dout_alt;
        logic sclk_prev;
        logic din_prev;
        logic [1:0] idle_ticks;
        logic [2:0] pin_out;
        logic [2:0] pin_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } core_t;

endpackage

// file: rtl/sync_serial_channel_core.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "sscc_defines.svh"
// Operation
// - Clock rests at selected idle level
// - Phase select picks latch edge versus shift edge
// - Four enabled error kinds raise error request
// - Busy visible only when on, hardware owned
// - Master busy from load until last word
// - Slave busy through back-to-back words
// - Low control bits show shift count when on
// - Sixteen-bit buffers, data right aligned
// - Baud reload readable and writable when off
// - Baud down counter reloads, starts on enable
// - Reading reload when on returns count
// - Bit rate is clock over 2*(reload+1)
// - Three interrupt control registers, fixed layout
// - Pin directions set by software, not swapped by role
// - Unused alternate output held high
// - Serial lines rerouted automatically by role
// - Each pin individually open drain
// - Switching off aborts, outputs return high
// - Master drives clock, slave is default
// - Word length is field plus one
// - Bit order select, LSB or MSB first
module sync_serial_channel_core (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shift clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Controller-output data pin
    input wire logic controller_out_line_in,
    output logic controller_out_line_out,
    output logic controller_out_line_oe,
    // Controller-input data pin
    input wire logic controller_in_line_in,
    output logic controller_in_line_out,
    output logic controller_in_line_oe
);

    sscc_pkg::core_t r;
    sscc_pkg::core_t next_r;
    logic [2:0] pin_sync;
    logic baud_tick;
    logic [15:0] baud_count;

    pin_sync_2ff u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({controller_in_line_in, controller_out_line_in, sclk_in}),
        .q(pin_sync)
    );

    // Runs from enable onward, also in slave role for rate checks
    baud_down_counter u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(r.en),
        .reload(r.br),
        .tick(baud_tick),
        .count(baud_count)
    );

    function automatic logic [3:0] bit_sel(input logic hb,
                                           input logic [4:0] nb,
                                           input logic [4:0] k);
        logic [4:0] t;
        t = hb ? (nb - 5'd1 - k) : k;
        return t[3:0];
    endfunction

    always_comb begin
        logic [15:0] idx;
        logic acc;
        logic wr;
        logic rd;
        logic hit;
        logic [4:0] nbits;
        logic din;
        logic sck;
        logic lead;
        logic trail;
        logic ev;
        logic e;
        logic done;
        logic [3:0] bi;
        logic [3:0] err_set;
        logic [2:0] alt;
        logic [31:0] rv;
        next_r = r;
        idx = paddr[17:2];
        acc = psel & penable;
        wr = acc & pwrite & r.pready;
        rd = acc & ~pwrite & r.pready;
        nbits = {1'b0, r.bm} + 5'd1;
        din = r.ms ? pin_sync[2] : pin_sync[1];
        sck = pin_sync[0];
        lead = r.en & ~r.ms & (sck != r.sclk_prev) & (sck != r.po);
        trail = r.en & ~r.ms & (sck != r.sclk_prev) & (sck == r.po);
        ev = 1'b0;
        e = 1'b0;
        done = 1'b0;
        bi = 4'h0;
        err_set = 4'h0;
        alt = 3'h7;
        rv = 32'h0;
        next_r.sclk_prev = sck;
        next_r.din_prev = din;

        // Read data prepared one cycle ahead of the pready edge
        hit = 1'b1;
        case (idx)
            `IDX_CTRL: begin
                rv[`CTRL_EN] = r.en;
                rv[`CTRL_MS] = r.ms;
                if (r.en) begin
                    rv[`CTRL_BSY] = r.busy;
                    rv[`CTRL_ERR] = r.err_flag;
                    rv[`CTRL_BM] = r.bc;
                end else begin
                    rv[`CTRL_ERR] = r.err_en;
                    rv[`CTRL_PO] = r.po;
                    rv[`CTRL_PH] = r.ph;
                    rv[`CTRL_HB] = r.hb;
                    rv[`CTRL_BM] = r.bm;
                end
            end
            `IDX_TB: rv[15:0] = r.tb;
            `IDX_RB: rv[15:0] = r.rb;
            `IDX_BR: rv[15:0] = r.en ? baud_count : r.br;
            `IDX_TIC: rv[7:0] = r.tic;
            `IDX_RIC: rv[7:0] = r.ric;
            `IDX_EIC: rv[7:0] = r.eic;
            `IDX_PIN: begin
                rv[`PIN_LATCH] = r.latch;
                rv[`PIN_DIR] = r.dir;
                rv[`PIN_OD] = r.od;
            end
            default: hit = 1'b0;
        endcase
        next_r.pready = acc & ~r.pready;
        next_r.pslverr = acc & ~r.pready & ~hit;
        next_r.prdata = (acc & ~r.pready) ? rv : 32'h0;

        // Which half of the control register is reached follows old enable
        if (wr) begin
            case (idx)
                `IDX_CTRL: begin
                    next_r.en = pwdata[`CTRL_EN];
                    next_r.ms = pwdata[`CTRL_MS];
                    if (r.en) begin
                        next_r.err_flag = pwdata[`CTRL_ERR];
                    end else begin
                        next_r.err_en = pwdata[`CTRL_ERR];
                        next_r.po = pwdata[`CTRL_PO];
                        next_r.ph = pwdata[`CTRL_PH];
                        next_r.hb = pwdata[`CTRL_HB];
                        next_r.bm = pwdata[`CTRL_BM];
                    end
                end
                `IDX_TB: begin
                    next_r.tb = pwdata[15:0];
                    // No transfer is queued while off
                    next_r.tb_full = r.en;
                end
                `IDX_BR: begin
                    // Ignored while on; the count would be corrupted
                    if (!r.en) begin
                        next_r.br = pwdata[15:0];
                    end
                end
                `IDX_TIC: next_r.tic = pwdata[7:0];
                `IDX_RIC: next_r.ric = pwdata[7:0];
                `IDX_EIC: next_r.eic = pwdata[7:0];
                `IDX_PIN: begin
                    next_r.latch = pwdata[`PIN_LATCH];
                    next_r.dir = pwdata[`PIN_DIR];
                    next_r.od = pwdata[`PIN_OD];
                end
                default: ;
            endcase
        end
        if (rd && idx == `IDX_RB) begin
            next_r.rb_full = 1'b0;
        end

        // Start of a word; a slave may be clocked with nothing queued
        if (next_r.en && r.st == sscc_pkg::XF_IDLE &&
            (next_r.tb_full || lead)) begin
            next_r.st = sscc_pkg::XF_RUN;
            next_r.busy = 1'b1;
            next_r.k = 5'd0;
            next_r.edge2 = 1'b0;
            next_r.bc = 4'h0;
            next_r.rx = 16'h0000;
            next_r.idle_ticks = 2'h0;
            if (next_r.tb_full) begin
                next_r.tx = next_r.tb;
                next_r.tb_full = 1'b0;
                next_r.tic[`IC_REQ] = 1'b1;
            end else begin
                next_r.tx = 16'hffff;
                err_set[`ERR_TX] = r.err_en[`ERR_TX];
            end
            bi = bit_sel(r.hb, nbits, 5'd0);
            next_r.dout_alt = next_r.tx[bi];
        end

        // Master edges come from the baud tick, slave edges from the pin
        case (next_r.st)
            sscc_pkg::XF_RUN: begin
                if (next_r.en && r.ms && r.st == sscc_pkg::XF_RUN) begin
                    ev = baud_tick;
                    e = r.edge2;
                end else if (next_r.en && !r.ms) begin
                    ev = lead | trail;
                    e = trail;
                end
            end
            sscc_pkg::XF_IDLE: ev = 1'b0;
            default: ev = 1'b0;
        endcase

        if (ev) begin
            next_r.idle_ticks = 2'h0;
            next_r.edge2 = ~e;
            if (r.ms) begin
                next_r.sclk_alt = ~r.sclk_alt;
            end
            bi = bit_sel(r.hb, nbits, next_r.k);
            if (e ^ r.ph) begin
                next_r.rx[bi] = din;
                // Data moving on the sampling edge means a phase slip
                if (!r.ms && din != r.din_prev) begin
                    err_set[`ERR_PHASE] = r.err_en[`ERR_PHASE];
                end
                if (!r.ph) begin
                    next_r.k = next_r.k + 5'd1;
                end
            end else begin
                next_r.bc = r.bc + 4'h1;
                if (r.ph) begin
                    next_r.k = next_r.k + 5'd1;
                    if (next_r.k < nbits) begin
                        bi = bit_sel(r.hb, nbits, next_r.k);
                        next_r.dout_alt = next_r.tx[bi];
                    end
                end else begin
                    next_r.dout_alt = next_r.tx[bi];
                end
            end
            done = e && (next_r.k == nbits);
        end else if (baud_tick && !r.ms &&
                     next_r.st == sscc_pkg::XF_RUN) begin
            // Slave clock slower than the programmed rate
            if (r.idle_ticks == `BAUD_ERR_TICKS) begin
                err_set[`ERR_BAUD] = r.err_en[`ERR_BAUD];
            end else begin
                next_r.idle_ticks = r.idle_ticks + 2'h1;
            end
        end

        if (done) begin
            if (next_r.rb_full) begin
                err_set[`ERR_RX] = r.err_en[`ERR_RX];
            end
            next_r.rb = next_r.rx;
            next_r.rb_full = 1'b1;
            next_r.ric[`IC_REQ] = 1'b1;
            if (next_r.tb_full) begin
                // Queued word follows with busy left standing
                next_r.tx = next_r.tb;
                next_r.tb_full = 1'b0;
                next_r.tic[`IC_REQ] = 1'b1;
                next_r.k = 5'd0;
                next_r.edge2 = 1'b0;
                next_r.bc = 4'h0;
                next_r.rx = 16'h0000;
                bi = bit_sel(r.hb, nbits, 5'd0);
                next_r.dout_alt = next_r.tx[bi];
            end else begin
                next_r.st = sscc_pkg::XF_IDLE;
                next_r.busy = 1'b0;
            end
        end

        // Hardware set wins over a software write in the same cycle
        next_r.err_flag = next_r.err_flag | err_set;
        if (|err_set) begin
            next_r.eic[`IC_REQ] = 1'b1;
        end

        if (!next_r.en) begin
            next_r.st = sscc_pkg::XF_IDLE;
            next_r.busy = 1'b0;
            next_r.sclk_alt = 1'b1;
            next_r.dout_alt = 1'b1;
            next_r.idle_ticks = 2'h0;
        end else if (next_r.ms && next_r.st == sscc_pkg::XF_IDLE) begin
            next_r.sclk_alt = next_r.po;
        end

        // Alternate outputs unused in this role stay high
        if (next_r.en && next_r.ms) begin
            alt[0] = next_r.sclk_alt;
            alt[1] = next_r.dout_alt;
        end else if (next_r.en) begin
            alt[2] = next_r.dout_alt;
        end
        next_r.pin_out = alt & next_r.latch;
        // Open drain pins float instead of driving high
        next_r.pin_oe = next_r.dir & (~next_r.od | ~next_r.pin_out);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.br <= `BR_RESET;
            r.tic <= `IC_RESET;
            r.ric <= `IC_RESET;
            r.eic <= `IC_RESET;
            r.latch <= `PIN_RESET;
            r.dir <= `PIN_RESET;
            r.od <= `PIN_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign sclk_out = r.pin_out[0];
    assign sclk_oe = r.pin_oe[0];
    assign controller_out_line_out = r.pin_out[1];
    assign controller_out_line_oe = r.pin_oe[1];
    assign controller_in_line_out = r.pin_out[2];
    assign controller_in_line_oe = r.pin_oe[2];

endmodule

// file: test/far_slave.sv
`timescale 1ns/1ps
module far_slave (
    // Link pins
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Frame setup
    input wire logic arm,
    input wire logic po,
    input wire logic msb,
    input wire logic [4:0] n,
    input wire logic [15:0] word,
    output logic [15:0] got
);
    logic [4:0] i = 5'd31;
    logic b_last = 1'b0;
    wire b = msb ? word[n - 5'd1 - i] : word[i];
    // Outside a frame show the inverse, never a stale bit
    assign miso = (i < n) ? b : ~b_last;
    always @(posedge arm) begin
        i = 5'd0;
        got = 16'h0;
    end
    // Phase one only: leading edge latches, trailing edge shifts
    always @(sclk) begin
        if (sclk !== po && i < n) begin
            got[msb ? n - 5'd1 - i : i] = mosi;
        end else if (sclk === po && i < n) begin
            b_last = b;
            i = i + 5'd1;
        end
    end
endmodule

// file: test/sscc_monitor.sv
`timescale 1ns/1ps
`include "sscc_defines.svh"
module sscc_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic controller_out_line_out,
    input wire logic controller_out_line_oe,
    input wire logic controller_in_line_out,
    input wire logic controller_in_line_oe
);
    logic en;
    logic en_q;
    logic sclk_q;
    logic [15:0] br;
    logic [15:0] gap;
    logic [3:0] bm;
    logic [2:0] od;
    wire [15:0] idx = paddr[17:2];
    wire done = psel && penable && pready;
    wire rd = done && !pwrite;
    wire rd_ctrl = rd && idx == `IDX_CTRL;
    // Shadows follow completed writes only, as the slave does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= 1'b0;
            en_q <= 1'b0;
            sclk_q <= 1'b0;
            br <= 16'h0;
            gap <= 16'h0;
            bm <= 4'h0;
            od <= 3'h0;
        end else begin
            en_q <= en;
            sclk_q <= sclk_out;
            gap <= (sclk_out != sclk_q) ? 16'h0 : gap + {15'h0, ~&gap};
            if (done && pwrite && idx == `IDX_CTRL) begin
                en <= pwdata[15];
                if (!en) bm <= pwdata[3:0];
            end
            if (done && pwrite && idx == `IDX_BR && !en) br <= pwdata[15:0];
            if (done && pwrite && idx == `IDX_PIN) od <= pwdata[18:16];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("Access not answered after one wait state");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    slverr_pair_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("Error response malformed");
    busy_hidden_a: assert property (rd_ctrl && !en |-> !prdata[12])
        else $error("Busy bit seen while off");
    len_field_a: assert property (rd_ctrl && !en |-> prdata[3:0] == bm)
        else $error("Length field not read back while off");
    br_off_a: assert property (rd && idx == `IDX_BR && !en |->
        prdata == {16'h0, br}) else $error("Baud reload readback wrong");
    br_live_a: assert property (rd && idx == `IDX_BR && en |->
        prdata[31:16] == 16'h0 && prdata[15:0] <= br)
        else $error("Live baud count out of range");
    ic_width_a: assert property (rd && (idx == `IDX_TIC ||
        idx == `IDX_RIC || idx == `IDX_EIC) |-> prdata[31:8] == 24'h0)
        else $error("Interrupt control wider than a byte");
    rb_align_a: assert property (rd && idx == `IDX_RB |->
        (prdata >> ({1'b0, bm} + 5'd1)) == 32'h0)
        else $error("Receive data not right aligned");
    half_bit_a: assert property (sclk_out != sclk_q && en && en_q &&
        sclk_oe |-> gap >= br) else $error("Shift clock edge too early");
    od_low_a: assert property (!(od[0] && sclk_oe && sclk_out) &&
        !(od[1] && controller_out_line_oe && controller_out_line_out) &&
        !(od[2] && controller_in_line_oe && controller_in_line_out))
        else $error("Open drain pin driven high");
    busy_c: cover property (rd_ctrl && en && prdata[12]);
    slverr_c: cover property (pslverr);
    toggle_c: cover property (sclk_out != sclk_q && en && sclk_oe);
endmodule
bind sync_serial_channel_core sscc_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .controller_out_line_out(controller_out_line_out),
    .controller_out_line_oe(controller_out_line_oe),
    .controller_in_line_out(controller_in_line_out),
    .controller_in_line_oe(controller_in_line_oe)
);

// file: test/tb.sv
`timescale 1ns/1ps
`include "sscc_defines.svh"
module tb;
    localparam logic [15:0] BR = 16'h0003;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, sclk_out, sclk_oe, err;
    logic co_out, co_oe, ci_out, ci_oe, miso;
    logic arm = 1'b0;
    logic hb = 1'b0;
    logic [4:0] nb = 5'd8;
    logic [15:0] sw = 16'h0;
    logic [15:0] got;
    logic [15:0] ics [3] = '{`IDX_TIC, `IDX_RIC, `IDX_EIC};
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0 = 0;
    int per = 0;
    // Released clock and controller-out lines sit on their pull-ups; controller-in follows the peer
    wire sclk_w = sclk_oe ? sclk_out : 1'b1;
    wire co_w = co_oe ? co_out : 1'b1;
    wire ci_w = ci_oe ? ci_out : miso;
    sync_serial_channel_core dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .controller_out_line_in(co_w), .controller_out_line_out(co_out),
        .controller_out_line_oe(co_oe), .controller_in_line_in(ci_w),
        .controller_in_line_out(ci_out), .controller_in_line_oe(ci_oe)
    );
    far_slave peer_u (
        .sclk(sclk_w), .mosi(co_w), .miso(miso), .arm(arm), .po(1'b0),
        .msb(hb), .n(nb), .word(sw), .got(got)
    );
    initial begin
        forever #10 pclk = ~pclk;
    end
    always @(negedge pclk) cyc++;
    always @(posedge sclk_out) begin
        per = cyc - t0;
        t0 = cyc;
    end
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic wait_bit(input logic [15:0] idx, input int b,
                            input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, idx, 32'h0);
            n++;
        end while (rd[b] !== v && n < 100);
        if (n >= 100) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge pclk);
    endtask
    task automatic regs_test();
        check(32'({sclk_oe, co_oe, ci_oe, pready}), 32'h0);
        apb(1'b0, `IDX_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `IDX_BR, 32'h0);
        check(rd, 32'h0);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, ics[k], 32'h0);
            check(rd, 32'h0);
            apb(1'b1, ics[k], 32'hffff_ff7d);
            apb(1'b0, ics[k], 32'h0);
            check(rd, 32'h0000_007d);
            apb(1'b1, ics[k], 32'h0);
        end
        apb(1'b0, 16'h0001, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        apb(1'b1, `IDX_BR, {16'h0, BR});
        apb(1'b0, `IDX_BR, 32'h0);
        check(rd, {16'h0, BR});
        apb(1'b1, `IDX_CTRL, 32'h0000_8000);
        apb(1'b0, `IDX_BR, 32'h0);
        check(32'(rd <= {16'h0, BR}), 32'h1);
        apb(1'b1, `IDX_BR, 32'h0000_0009);
        apb(1'b1, `IDX_CTRL, 32'h0);
        apb(1'b0, `IDX_BR, 32'h0);
        check(rd, {16'h0, BR});
    endtask
    task automatic slave_pins();
        apb(1'b1, `IDX_PIN, 32'h0000_0407);
        apb(1'b1, `IDX_CTRL, 32'h0000_8047);
        settle();
        check(32'({sclk_oe, co_oe, ci_oe, ci_out}), 32'h3);
        apb(1'b1, `IDX_PIN, 32'h0004_0407);
        settle();
        check(32'({ci_oe, ci_out}), 32'h1);
        apb(1'b1, `IDX_CTRL, 32'h0);
        apb(1'b1, `IDX_PIN, 32'h0000_0307);
    endtask
    task automatic master_xfer(input logic [3:0] bm, input logic h,
                               input logic [15:0] tx, input logic [15:0] sv);
        logic [15:0] m;
        m = 16'hffff >> (4'hf - bm);
        nb <= {1'b0, bm} + 5'd1;
        hb <= h;
        sw <= sv;
        apb(1'b1, `IDX_RIC, 32'h0);
        apb(1'b1, `IDX_CTRL, {16'h0, 2'b11, 6'h0, 3'b001, h, bm});
        settle();
        // Armed after the enable edge, which the peer would count as a shift
        arm <= 1'b1;
        check(32'(sclk_out), 32'h0);
        apb(1'b1, `IDX_TB, {16'h0, tx});
        apb(1'b0, `IDX_CTRL, 32'h0);
        check(32'(rd[12]), 32'h1);
        wait_bit(`IDX_CTRL, 12, 1'b0);
        check(32'(got & m), 32'(tx & m));
        apb(1'b0, `IDX_RB, 32'h0);
        check(rd, {16'h0, sv & m});
        apb(1'b0, `IDX_RIC, 32'h0);
        check(32'(rd[7]), 32'h1);
        check(32'(per), 32'(2 * (BR + 1)));
        apb(1'b1, `IDX_CTRL, 32'h0);
        arm <= 1'b0;
    endtask
    task automatic queued();
        apb(1'b1, `IDX_RIC, 32'h0);
        // Phase zero, receive error enabled, first word left unread
        apb(1'b1, `IDX_CTRL, 32'h0000_c217);
        apb(1'b1, `IDX_TB, 32'h0000_0055);
        apb(1'b1, `IDX_TB, 32'h0000_00aa);
        wait_bit(`IDX_RIC, 7, 1'b1);
        apb(1'b0, `IDX_CTRL, 32'h0);
        check(32'(rd[12]), 32'h1);
        wait_bit(`IDX_CTRL, 12, 1'b0);
        check(32'(rd[9]), 32'h1);
        check(32'(rd[3:0]), 32'h8);
        apb(1'b0, `IDX_EIC, 32'h0);
        check(32'(rd[7]), 32'h1);
        apb(1'b1, `IDX_CTRL, 32'h0);
    endtask
    task automatic abort_test();
        apb(1'b1, `IDX_CTRL, 32'h0000_c077);
        settle();
        check(32'(sclk_out), 32'h1);
        apb(1'b1, `IDX_TB, 32'h0);
        apb(1'b1, `IDX_CTRL, 32'h0);
        settle();
        check(32'({sclk_out, co_out}), 32'h3);
        apb(1'b1, `IDX_CTRL, 32'h0000_c037);
        apb(1'b0, `IDX_CTRL, 32'h0);
        check(32'(rd[12]), 32'h0);
        apb(1'b1, `IDX_CTRL, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        regs_test();
        slave_pins();
        master_xfer(4'h7, 1'b1, 16'h00a5, 16'h003c);
        master_xfer(4'h4, 1'b0, 16'h0013, 16'h000b);
        master_xfer(4'hf, 1'b1, 16'hbeef, 16'h1234);
        master_xfer(4'h1, 1'b0, 16'h0002, 16'h0001);
        queued();
        abort_test();
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        fails++;
        stop_test();
    end
endmodule
